// [bench/jtag_tester.sv]
`timescale 1ns/1ps
`default_nettype none
module jtag_tester (
  output logic test_clk,
  output logic test_mode_sel,
  output logic test_mode_sel_en,
  output logic test_data_in,
  output logic test_data_in_en,
  input wire logic test_data_out,
  input wire logic test_data_out_en
);
  initial begin
    test_clk = 1'b0;
    test_mode_sel = 1'b1;
    test_mode_sel_en = 1'b0;
    test_data_in = 1'b0;
    test_data_in_en = 1'b0;
  end
  // One test clock period; the clock stands low between calls
  // state steered by mode select
  task automatic step(input logic m, input logic d, output logic o, output logic oe);
    #1;
    test_mode_sel_en = m ? 1'($urandom_range(1)) : 1'b1;
    test_mode_sel = test_mode_sel_en ? m : ~test_mode_sel;
    test_data_in_en = d ? 1'($urandom_range(1)) : 1'b1;
    test_data_in = test_data_in_en ? d : ~test_data_in;
    #79;
    oe = test_data_out_en;
    // A released data out has no keeper; show it as the opposite level
    o = oe ? test_data_out : ~test_data_out;
    test_clk = 1'b1;
    #80;
    test_clk = 1'b0;
  endtask
endmodule // jtag_tester
`default_nettype wire

// [bench/sram_jtag_test_access_port_test.sv]
`timescale 1ns/1ps
`default_nettype none
module sram_jtag_test_access_port_test;
  import tap_pkg::*;
  localparam int PINS = 8;
  localparam int PADS = 2;
  // Arbitrary identification value
  localparam logic [31:0] ID = 32'h5a3c_0f01;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic test_clk, test_mode_sel, test_mode_sel_en, test_data_in, test_data_in_en, test_data_out, test_data_out_en;
  logic [PINS-1:0] pin_levels = '0;
  logic [PINS-1:0] pin_drive;
  logic pin_drive_override, ram_outputs_off;
  logic [63:0] so;
  int n_fail = 0;
  int comparisons = 0;
  int ir_m;
  always #2 sys_clk = ~sys_clk;
  sram_test_port #(.PIN_COUNT(PINS), .PAD_COUNT(PADS), .ID_VALUE(ID)) i_dut (.sys_clk(sys_clk),
    .reset(reset), .test_clk(test_clk), .test_mode_sel(test_mode_sel), .test_mode_sel_en(test_mode_sel_en),
    .test_data_in(test_data_in), .test_data_in_en(test_data_in_en), .test_data_out(test_data_out),
    .test_data_out_en(test_data_out_en), .pin_levels(pin_levels), .pin_drive(pin_drive),
    .pin_drive_override(pin_drive_override), .ram_outputs_off(ram_outputs_off));
  jtag_tester i_tester (.test_clk(test_clk), .test_mode_sel(test_mode_sel), .test_mode_sel_en(test_mode_sel_en),
    .test_data_in(test_data_in), .test_data_in_en(test_data_in_en), .test_data_out(test_data_out),
    .test_data_out_en(test_data_out_en));
  task automatic tally_and_finish();
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic st(input logic m, input logic d, input logic en_exp, output logic o);
    logic oe;
    i_tester.step(m, d, o, oe);
    chk({63'h0, oe}, {63'h0, en_exp}); // enable in shift only
  endtask
  // Scan from idle back to idle
  task automatic scan(input bit ir, input int n, input logic [63:0] si);
    logic o;
    st(1'b1, 1'b0, 1'b0, o);
    if (ir) st(1'b1, 1'b0, 1'b0, o);
    st(1'b0, 1'b0, 1'b0, o);
    st(1'b0, 1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      st(i == n - 1, si[i], 1'b1, o);
      so[i] = o;
    end
    chk({62'h0, pin_drive_override, ram_outputs_off}, {62'h0, ir_m == 0, ir_m == 2}); // old instruction
    st(1'b1, 1'b0, 1'b0, o);
    st(1'b0, 1'b0, 1'b0, o);
  endtask
  task automatic load(input int code);
    scan(1'b1, IR_WIDTH, 64'(code));
    chk({62'h0, so[1:0]}, {62'h0, 2'h1}); // capture pattern
    ir_m = code;
    chk({62'h0, pin_drive_override, ram_outputs_off}, {62'h0, code == 0, code == 2}); // codes
  endtask
  task automatic dr();
    logic [63:0] si, exp, mask;
    int n;
    si = {$urandom, $urandom};
    pin_levels = PINS'($urandom);
    n = ir_m == 1 ? ID_WIDTH : (ir_m == 0 || ir_m == 2 || ir_m == 4) ? PINS + PADS : 5 + $urandom_range(40);
    case (ir_m)
      1: exp = 64'(ID);
      0, 2, 4: exp = 64'({{PADS{1'b1}}, pin_levels});
      default: exp = {si[62:0], 1'b0};
    endcase
    mask = (64'h1 << n) - 64'h1;
    scan(1'b0, n, si);
    chk(so & mask, exp & mask); // scan out
    if (ir_m == 0 || ir_m == 4) chk(64'(pin_drive), 64'(si[PINS-1:0])); // updated drive
  endtask
  initial begin : main
    logic o;
    void'($urandom(32'h3b61));
    repeat (16) @(posedge sys_clk);
    #1 reset = 1'b0;
    chk({61'h0, test_data_out_en, pin_drive_override, ram_outputs_off}, 64'h0); // idle port
    repeat (6) st(1'b1, 1'b0, 1'b0, o);
    st(1'b0, 1'b0, 1'b0, o);
    ir_m = 1;
    dr(); // default instruction
    for (int c = 0; c < 8; c++) begin
      load(c);
      dr();
    end
    // Abort in mid shift by holding mode select high
    st(1'b1, 1'b0, 1'b0, o);
    st(1'b0, 1'b0, 1'b0, o);
    st(1'b0, 1'b0, 1'b0, o);
    st(1'b0, 1'b1, 1'b1, o);
    st(1'b1, 1'b0, 1'b1, o);
    repeat (4) st(1'b1, 1'b0, 1'b0, o);
    st(1'b0, 1'b0, 1'b0, o);
    ir_m = 1;
    dr(); // reset by mode select
    load(0);
    // Power-up reset with the test clock stopped must drop the held instruction
    @(posedge sys_clk);
    #1 reset = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chk({61'h0, test_data_out_en, pin_drive_override, ram_outputs_off}, 64'h0); // preset
    reset = 1'b0;
    repeat (3) st(1'b1, 1'b0, 1'b0, o);
    st(1'b0, 1'b0, 1'b0, o);
    ir_m = 1;
    dr(); // preset after reset
    tally_and_finish();
  end
  initial begin : watchdog
    #200000;
    n_fail++;
    tally_and_finish();
  end
endmodule // sram_jtag_test_access_port_test
`default_nettype wire

// [logic/sram_test_port.sv]
// Behaviour
// [RULE1] Inputs sampled on rising test clock, outputs launched on falling edge.
// [RULE2] Mode select steers the state machine; undriven reads as one.
// [RULE3] Data in feeds selected register; undriven reads as one.
// [RULE4] Data out enabled only in shift states, updated on falling edge.
// [RULE5] Five rising edges with mode select high force Test-Logic-Reset.
// [RULE6] Port resets itself at power-up without any test clock.
// [RULE7] With no test clock the port stays idle and harmless.
// [RULE8] Exactly one register sits between data in and data out.
// [RULE9] Selected register follows state and held instruction.
// [RULE10] Registers shift in on rising edge, shift out on falling edge.
// [RULE11] Instruction register is 3 bits, loaded only while in path.
// [RULE12] Held instruction governs idle and data register states.
// [RULE13] Instruction presets to identification at power-up and reset state.
// [RULE14] Bypass is one flip-flop between data in and data out.
// [RULE15] Boundary register captures pins in Capture-DR, shifts in Shift-DR.
// [RULE16] Boundary cells without a pin always capture one.
// [RULE17] Boundary register chosen by sample-Z, sample/preload and external test.
// [RULE18] Capture-IR loads 01 into low instruction bits.
// [RULE19] New instruction takes effect only at Update-IR.
// [RULE20] Codes: external test 000, identification 001, sample-Z 010 forces outputs off.
// [RULE21] Identification is 32 bits, captured from constant, bit 0 first out.
// [RULE22] Standard sixteen-state controller stepped by mode select.
`timescale 1ns/1ps
`default_nettype none
module sram_test_port
  import tap_pkg::*;
#(
  parameter int PIN_COUNT = 8,
  parameter int PAD_COUNT = 2,
  // Arbitrary neutral identification value
  parameter logic [31:0] ID_VALUE = 32'h0000_0001
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic test_clk,
  input wire logic test_mode_sel,
  input wire logic test_mode_sel_en,
  input wire logic test_data_in,
  input wire logic test_data_in_en,
  output logic test_data_out,
  output logic test_data_out_en,
  input wire logic [PIN_COUNT-1:0] pin_levels,
  output logic [PIN_COUNT-1:0] pin_drive,
  output logic pin_drive_override,
  output logic ram_outputs_off
);
  localparam int BSR_WIDTH = PIN_COUNT + PAD_COUNT;

  // Pad cells must exist and the identification value must end in one
  if (PIN_COUNT < 1 || PAD_COUNT < 1 || ID_VALUE[0] != 1'b1) begin : g_bad_params
    $error("sram_test_port: bad parameters");
  end

  // [RULE2] undriven pins read high
  logic tms;
  // [RULE3] undriven pins read high
  logic tdi;
  assign tms = test_mode_sel_en ? test_mode_sel : 1'b1;
  assign tdi = test_data_in_en ? test_data_in : 1'b1;

  // Power-up condition: reset seen in sys_clk domain is held as a level
  logic por_q;
  always_ff @(posedge sys_clk) begin
    por_q <= reset;
  end
  // [RULE6] immediate preset
  // Release is retimed to the test clock so no flop leaves reset on a runt edge
  logic por_s1_q, por_s2_q;
  always_ff @(posedge test_clk or posedge por_q) begin
    if (por_q) begin
      por_s1_q <= 1'b1;
      por_s2_q <= 1'b1;
    end else begin
      por_s1_q <= 1'b0;
      por_s2_q <= por_s1_q;
    end
  end
  // Pin levels come from the RAM side; two stages before capture
  logic [PIN_COUNT-1:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge test_clk) begin
    pin_s1_q <= pin_levels;
    pin_s2_q <= pin_s1_q;
  end
  logic tap_rst;
  assign tap_rst = por_s2_q;

  tap_state_type state_q, state_d;
  // [RULE22] standard transitions
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      TLR: state_d = tms ? TLR : RTI;
      RTI: state_d = tms ? SEL_DR : RTI;
      SEL_DR: state_d = tms ? SEL_IR : CAP_DR;
      CAP_DR: state_d = tms ? EX1_DR : SH_DR;
      SH_DR: state_d = tms ? EX1_DR : SH_DR;
      EX1_DR: state_d = tms ? UPD_DR : PA_DR;
      PA_DR: state_d = tms ? EX2_DR : PA_DR;
      EX2_DR: state_d = tms ? UPD_DR : SH_DR;
      UPD_DR: state_d = tms ? SEL_DR : RTI;
      SEL_IR: state_d = tms ? TLR : CAP_IR;
      CAP_IR: state_d = tms ? EX1_IR : SH_IR;
      SH_IR: state_d = tms ? EX1_IR : SH_IR;
      EX1_IR: state_d = tms ? UPD_IR : PA_IR;
      PA_IR: state_d = tms ? EX2_IR : PA_IR;
      EX2_IR: state_d = tms ? UPD_IR : SH_IR;
      UPD_IR: state_d = tms ? SEL_DR : RTI;
    endcase
  end

  // [RULE5] five ones reach TLR from any state
  // [RULE6] power-up reset places controller in TLR
  // [RULE1] sampled on rising edge
  always_ff @(posedge test_clk or posedge tap_rst) begin
    if (tap_rst)
      state_q <= TLR;
    else
      state_q <= state_d;
  end

  // [RULE11] shift only while in path
  logic [IR_WIDTH-1:0] ir_shift_q, ir_q;
  always_ff @(posedge test_clk or posedge tap_rst) begin
    if (tap_rst)
      ir_shift_q <= IR_RESET_VALUE;
    else if (state_q == CAP_IR)
      // [RULE18] capture pattern
      ir_shift_q <= {ir_q[IR_WIDTH-1:2], IR_CAPTURE_LOW};
    else if (state_q == SH_IR)
      ir_shift_q <= {tdi, ir_shift_q[IR_WIDTH-1:1]};
  end

  // [RULE13] preset to identification
  // [RULE19] applied at update
  always_ff @(negedge test_clk or posedge tap_rst) begin
    if (tap_rst)
      ir_q <= IR_RESET_VALUE;
    else if (state_q == TLR)
      ir_q <= IR_RESET_VALUE;
    else if (state_q == UPD_IR)
      ir_q <= ir_shift_q;
  end

  // [RULE17] boundary selection
  // [RULE20] instruction decode
  logic sel_bsr, sel_id;
  assign sel_bsr = (ir_q == INSTR_EXTEST) || (ir_q == INSTR_SAMPLE_Z) || (ir_q == INSTR_SAMPLE_PRELOAD);
  assign sel_id = (ir_q == INSTR_IDCODE);

  logic bypass_q;
  logic [ID_WIDTH-1:0] id_q;
  logic [BSR_WIDTH-1:0] bsr_q;
  logic [PIN_COUNT-1:0] upd_q;

  // [RULE14] single bypass stage
  always_ff @(posedge test_clk) begin
    if (state_q == CAP_DR)
      bypass_q <= 1'b0;
    else if (state_q == SH_DR && !sel_bsr && !sel_id)
      bypass_q <= tdi;
  end

  // [RULE21] identification capture, bit 0 first
  always_ff @(posedge test_clk) begin
    if (state_q == CAP_DR && sel_id)
      id_q <= ID_VALUE;
    else if (state_q == SH_DR && sel_id)
      id_q <= {tdi, id_q[ID_WIDTH-1:1]};
  end

  // [RULE15] boundary capture and shift
  // [RULE16] pad cells capture one
  // [RULE10] shift in on rising edge
  always_ff @(posedge test_clk) begin
    if (state_q == CAP_DR && sel_bsr)
      bsr_q <= {{PAD_COUNT{1'b1}}, pin_s2_q};
    else if (state_q == SH_DR && sel_bsr)
      bsr_q <= {tdi, bsr_q[BSR_WIDTH-1:1]};
  end

  always_ff @(negedge test_clk or posedge tap_rst) begin
    if (tap_rst)
      upd_q <= '0;
    else if (state_q == UPD_DR && sel_bsr)
      upd_q <= bsr_q[PIN_COUNT-1:0];
  end

  // [RULE9] path chosen from state and instruction
  // [RULE8] one register in path
  logic serial_bit;
  always_comb begin
    if (state_q == SH_IR)
      serial_bit = ir_shift_q[0];
    else if (sel_bsr)
      serial_bit = bsr_q[0];
    else if (sel_id)
      serial_bit = id_q[0];
    else
      serial_bit = bypass_q;
  end

  // [RULE4] drive only while shifting, falling edge
  // [RULE7] idle port keeps data out off
  always_ff @(negedge test_clk or posedge tap_rst) begin
    if (tap_rst) begin
      test_data_out <= 1'b0;
      test_data_out_en <= 1'b0;
    end else begin
      test_data_out <= serial_bit;
      test_data_out_en <= (state_q == SH_DR) || (state_q == SH_IR);
    end
  end

  // [RULE12] held instruction steers pins
  assign pin_drive = upd_q;
  assign pin_drive_override = (ir_q == INSTR_EXTEST);
  assign ram_outputs_off = (ir_q == INSTR_SAMPLE_Z);

  property p_five_ones;
    @(posedge test_clk) disable iff (tap_rst)
      tms [*5] |=> state_q == TLR;
  endproperty
  a_five_ones: assert property (p_five_ones) else $error("no reset after five ones"); // [RULE5]

  property p_tdo_en;
    @(posedge test_clk) disable iff (tap_rst)
      test_data_out_en == (state_q == SH_DR || state_q == SH_IR);
  endproperty
  a_tdo_en: assert property (p_tdo_en) else $error("data out enabled outside shift"); // [RULE4]

  property p_ir_capture;
    @(posedge test_clk) disable iff (tap_rst)
      state_q == CAP_IR |=> ir_shift_q[1:0] == IR_CAPTURE_LOW;
  endproperty
  a_ir_capture: assert property (p_ir_capture) else $error("capture pattern wrong"); // [RULE18]

  property p_id_capture;
    @(posedge test_clk) disable iff (tap_rst)
      (state_q == CAP_DR && sel_id) |=> id_q == ID_VALUE;
  endproperty
  a_id_capture: assert property (p_id_capture) else $error("identification not captured"); // [RULE21]

  property p_tlr_ir;
    @(posedge test_clk) disable iff (tap_rst)
      state_q == TLR ##1 state_q == TLR |-> ir_q == INSTR_IDCODE;
  endproperty
  a_tlr_ir: assert property (p_tlr_ir) else $error("instruction not preset"); // [RULE13]

  property p_ir_stable;
    @(posedge test_clk) disable iff (tap_rst)
      (state_q != UPD_IR && state_q != TLR && $past(state_q) != UPD_IR && $past(state_q) != TLR) |-> $stable(ir_q);
  endproperty
  a_ir_stable: assert property (p_ir_stable) else $error("instruction changed outside update"); // [RULE19]

  property p_pad_one;
    @(posedge test_clk) disable iff (tap_rst)
      (state_q == CAP_DR && sel_bsr) |=> &bsr_q[BSR_WIDTH-1:PIN_COUNT];
  endproperty
  a_pad_one: assert property (p_pad_one) else $error("pad cell not one"); // [RULE16]

  property p_bypass;
    @(posedge test_clk) disable iff (tap_rst)
      (state_q == SH_DR && ir_q == INSTR_BYPASS) |=> bypass_q == $past(tdi);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass stage wrong"); // [RULE14]

  property p_boundary_shift;
    @(posedge test_clk) disable iff (tap_rst)
      (state_q == SH_DR && sel_bsr) |=> bsr_q[BSR_WIDTH-1] == $past(tdi);
  endproperty
  a_boundary_shift: assert property (p_boundary_shift) else $error("boundary shift wrong"); // [RULE15]

  // Run of mode select ones, saturating at the reset count
  logic [2:0] ones_run_q;
  always_ff @(posedge test_clk or posedge tap_rst) begin
    if (tap_rst)
      ones_run_q <= 3'h0;
    else if (!tms)
      ones_run_q <= 3'h0;
    else if (ones_run_q != 3'(RESET_TMS_COUNT))
      ones_run_q <= ones_run_q + 3'h1;
  end

  property p_tms_run;
    @(posedge test_clk) disable iff (tap_rst)
      ones_run_q == 3'(RESET_TMS_COUNT) |-> state_q == TLR;
  endproperty
  a_tms_run: assert property (p_tms_run) else $error("long run of mode select ones missed reset"); // [RULE5]

  property p_bypass_capture;
    @(posedge test_clk) disable iff (tap_rst)
      state_q == CAP_DR |=> !bypass_q;
  endproperty
  a_bypass_capture: assert property (p_bypass_capture) else $error("bypass did not capture zero"); // [RULE14]

  property p_pin_capture;
    @(posedge test_clk) disable iff (tap_rst)
      (state_q == CAP_DR && sel_bsr) |=> bsr_q[PIN_COUNT-1:0] == $past(pin_s2_q);
  endproperty
  a_pin_capture: assert property (p_pin_capture) else $error("pin levels not captured"); // [RULE15]

  property p_ir_update;
    @(posedge test_clk) disable iff (tap_rst)
      state_q == UPD_IR |=> ir_q == ir_shift_q;
  endproperty
  a_ir_update: assert property (p_ir_update) else $error("instruction not applied at update"); // [RULE19]

  property p_tdo_data;
    @(posedge test_clk) disable iff (tap_rst)
      test_data_out_en |-> test_data_out == serial_bit;
  endproperty
  a_tdo_data: assert property (p_tdo_data) else $error("data out not the selected register bit"); // [RULE10]

  property p_ir_shift;
    @(posedge test_clk) disable iff (tap_rst)
      state_q == SH_IR |=> ir_shift_q[IR_WIDTH-1] == $past(tdi);
  endproperty
  a_ir_shift: assert property (p_ir_shift) else $error("instruction shift wrong"); // [RULE11]

  property p_ir_hold;
    @(posedge test_clk) disable iff (tap_rst)
      (state_q != CAP_IR && state_q != SH_IR) |=> $stable(ir_shift_q);
  endproperty
  a_ir_hold: assert property (p_ir_hold) else $error("instruction shifted outside its path"); // [RULE11]

  property p_id_shift;
    @(posedge test_clk) disable iff (tap_rst)
      (state_q == SH_DR && sel_id) |=> id_q[ID_WIDTH-1] == $past(tdi);
  endproperty
  a_id_shift: assert property (p_id_shift) else $error("identification shift wrong"); // [RULE21]

  property p_upd_drive;
    @(posedge test_clk) disable iff (tap_rst)
      (state_q == UPD_DR && sel_bsr) |=> pin_drive == bsr_q[PIN_COUNT-1:0];
  endproperty
  a_upd_drive: assert property (p_upd_drive) else $error("pin drive not updated"); // [RULE12]

  c_ir_update: cover property (@(posedge test_clk) state_q == UPD_IR);
  c_id_shift: cover property (@(posedge test_clk) state_q == SH_DR && sel_id);
  c_bsr_shift: cover property (@(posedge test_clk) state_q == SH_DR && sel_bsr);
  c_tms_reset: cover property (@(posedge test_clk) state_q == SEL_IR ##1 state_q == TLR);
  c_sample_z: cover property (@(posedge test_clk) ir_q == INSTR_SAMPLE_Z && state_q == SH_DR);
endmodule // sram_test_port
`default_nettype wire

// [pkg/tap_pkg.sv]
package tap_pkg;
  localparam int IR_WIDTH = 3;
  localparam int ID_WIDTH = 32;
  localparam int RESET_TMS_COUNT = 5;
  localparam logic [2:0] INSTR_EXTEST = 3'h0;
  localparam logic [2:0] INSTR_IDCODE = 3'h1;
  localparam logic [2:0] INSTR_SAMPLE_Z = 3'h2;
  localparam logic [2:0] INSTR_SAMPLE_PRELOAD = 3'h4;
  localparam logic [2:0] INSTR_BYPASS = 3'h7;
  localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;
  localparam logic [2:0] IR_RESET_VALUE = INSTR_IDCODE;
  typedef enum logic [3:0] {
    TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
    SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
  } tap_state_type;
endpackage
